/* ddc_feature_pkg.sv */
// Purpose: Shared offsets, field positions, reset values and carrier types of the feature control bank.
// Assumes: Registers are eight bits wide and addressed by an eight-bit register index.
// Notes: Every number used by more than one file is named here once.
package ddc_feature_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_ALIGN_CTRL = 8'h3A;
  localparam logic [7:0] ADDR_DC_CTRL = 8'h40;
  localparam logic [7:0] ADDR_DC_VALUE_LO = 8'h41;
  localparam logic [7:0] ADDR_DC_VALUE_HI = 8'h42;
  localparam logic [7:0] ADDR_FLAG_CTRL = 8'h45;
  localparam logic [7:0] ADDR_UPPER_LO = 8'h47;
  localparam logic [7:0] ADDR_UPPER_HI = 8'h48;
  localparam logic [7:0] ADDR_LOWER_LO = 8'h49;
  localparam logic [7:0] ADDR_LOWER_HI = 8'h4A;
  localparam logic [7:0] ADDR_DWELL_LO = 8'h4B;
  localparam logic [7:0] ADDR_DWELL_HI = 8'h4C;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h51;
  localparam logic [7:0] ADDR_TUNE_B3 = 8'h52;
  localparam logic [7:0] ADDR_TUNE_B2 = 8'h53;
  localparam logic [7:0] ADDR_TUNE_B1 = 8'h54;
  localparam logic [7:0] ADDR_TUNE_B0 = 8'h55;
  localparam logic [7:0] ADDR_PHASE_HI = 8'h56;
  localparam logic [7:0] ADDR_PHASE_LO = 8'h57;
  localparam logic [7:0] ADDR_PATH_ALIGN = 8'h58;
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h59;
  localparam logic [7:0] ADDR_OSC_CTRL2 = 8'h5A;

  // Field positions of the alignment pulse control register.
  localparam int BIT_MASTER_EN = 0;
  localparam int BIT_CLKDIV_EN = 1;
  localparam int BIT_CLKDIV_ONCE = 2;
  // Field positions of the datapath alignment control register.
  localparam int BIT_TUNE_EN = 0;
  localparam int BIT_TUNE_ONCE = 1;
  localparam int BIT_FIR_EN = 4;
  localparam int BIT_FIR_ONCE = 5;
  localparam int BIT_QUARTER_EN = 6;
  localparam int BIT_QUARTER_ONCE = 7;
  // Field positions of the pin control register.
  localparam int BIT_PIN_EDGE_MODE = 1;
  localparam int BIT_PIN_RISING = 0;
  // Field positions of the Dc_offset_correction_control register.
  localparam int BIT_DC_FREEZE = 6;
  localparam int BIT_DC_K_HI = 5;
  localparam int BIT_DC_K_LO = 2;
  localparam int BIT_DC_EN = 1;
  localparam logic [3:0] DC_K_MAX = 4'hD;
  // Field positions of the threshold flag control register.
  localparam int BIT_FORCE_EN = 3;
  localparam int BIT_FORCE_VAL = 2;
  localparam int BIT_FLAG_EN = 0;
  // Field positions of the oscillator control registers.
  localparam int BIT_QUARTER_SYNC = 6;
  localparam int BIT_SPECTRAL_REV = 5;
  localparam int BIT_AMP_DITHER = 2;
  localparam int BIT_PHASE_DITHER = 1;
  localparam int BIT_LOW_LATENCY = 0;
  localparam logic [7:0] OSC_CTRL_FIXED_ONES = 8'h11;

  // Reset values.
  localparam logic [7:0] RST_ALIGN_CTRL = 8'h00;
  localparam logic [7:0] RST_DC_CTRL = 8'h00;
  localparam logic [7:0] RST_FLAG_CTRL = 8'h00;
  localparam logic [12:0] RST_LIMIT = 13'h0000;
  localparam logic [15:0] RST_DWELL = 16'h0000;
  localparam logic [7:0] RST_OSC_CTRL = 8'h51;
  localparam logic [31:0] RST_TUNING_WORD = 32'h4000_0000;
  localparam logic [15:0] RST_PHASE = 16'h0000;
  localparam logic [7:0] RST_PATH_ALIGN = 8'h00;
  localparam logic [7:0] RST_PIN_CTRL = 8'h00;
  localparam logic [7:0] RST_OSC_CTRL2 = 8'h01;

  // One alignment pulse per sub-function.
  typedef struct packed {
    logic clk_divider;
    logic fir;
    logic quarter_rate_oscillator;
    logic tunable_oscillator;
  } align_pulse_s;

  // Settings handed to the tunable oscillator and its neighbours.
  typedef struct packed {
    logic [31:0] tuning_word;
    logic [15:0] phase_offset;
    logic amplitude_dither;
    logic phase_dither;
    logic spectral_reversal;
    logic quarter_rate_sync;
    logic low_latency_select;
  } osc_cfg_s;

endpackage

/* align_pulse_detect.sv */
// Purpose: Turns the raw alignment pin into one-cycle alignment events.
// Assumes: The pin is asynchronous to i_clk and is sampled through two flip-flops.
// Notes: In level mode an event is raised on every cycle the pin stays high.
module align_pulse_detect (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic i_edge_mode,
  input wire logic i_rising,
  output logic o_event
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Two-stage synchroniser; only the second stage feeds logic.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Level, rising or falling sensitivity as selected.
  always_comb begin
    if (!i_edge_mode) begin
      o_event = sync_q;
    end else if (i_rising) begin
      o_event = sync_q & ~prev_q;
    end else begin
      o_event = ~sync_q & prev_q;
    end
  end

endmodule

/* threshold_flag_detect.sv */
// Purpose: Hysteresis comparator behind the threshold flag with a dwell count for release.
// Assumes: Magnitude arrives once per divided sample clock.
// Notes: A dwell of zero releases the flag on the first cycle below the lower limit.
module threshold_flag_detect #(
  parameter int MAG_W = 13,
  parameter int DWELL_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [MAG_W-1:0] i_magnitude,
  input wire logic [MAG_W-1:0] i_upper,
  input wire logic [MAG_W-1:0] i_lower,
  input wire logic [DWELL_W-1:0] i_dwell,
  output logic o_flag
);

  logic [DWELL_W-1:0] below_q;
  logic below;

  assign below = i_magnitude < i_lower;

  // Count consecutive cycles spent below the lower limit, saturating.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      below_q <= '0;
    end else if (!below) begin
      below_q <= '0;
    end else if (below_q != {DWELL_W{1'b1}}) begin
      below_q <= below_q + 1'b1;
    end
  end

  // Set above the upper limit; release only after the dwell has elapsed.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag <= 1'b0;
    end else if (i_magnitude > i_upper) begin
      o_flag <= 1'b1;
    end else if (below && below_q >= i_dwell) begin
      o_flag <= 1'b0;
    end
  end

endmodule

/* ddc_feature_control_bank.sv */
// Purpose: Feature control register bank of the downconverter: alignment, DC correction, flag, oscillator.
// Assumes: The serial control port decoder presents one register index, strobe and byte per access.
// Notes: Runs on the divided sample clock; reads answer one cycle after the read strobe.
module ddc_feature_control_bank #(
  parameter int SAMPLE_W = 16,
  parameter int MAG_W = 13,
  parameter int DWELL_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_align_pin,
  output ddc_feature_pkg::align_pulse_s o_align_pulse,
  input wire logic signed [SAMPLE_W-1:0] i_sample,
  output logic signed [SAMPLE_W-1:0] o_sample,
  input wire logic [MAG_W-1:0] i_magnitude,
  output logic o_threshold_flag,
  output ddc_feature_pkg::osc_cfg_s o_osc_cfg
);
  import ddc_feature_pkg::*;

  localparam int FRAC_W = 8;
  localparam int EST_W = SAMPLE_W + FRAC_W + 1;

  logic rst_meta_q;
  logic rst_n_q;
  logic [7:0] align_ctrl_q;
  logic [7:0] path_align_q;
  logic [7:0] pin_ctrl_q;
  logic [7:0] dc_ctrl_q;
  logic [7:0] flag_ctrl_q;
  logic [12:0] upper_q;
  logic [12:0] lower_q;
  logic [15:0] dwell_q;
  logic [7:0] osc_ctrl_q;
  logic [31:0] tuning_q;
  logic [15:0] phase_q;
  logic [7:0] osc_ctrl2_q;
  logic signed [EST_W-1:0] est_q;
  logic signed [EST_W-1:0] est_d;
  logic signed [EST_W-1:0] err;
  logic [3:0] k_eff;
  logic signed [SAMPLE_W-1:0] dc_value;
  logic pin_event;
  logic master_on;
  logic hit_clkdiv;
  logic hit_tune;
  logic hit_fir;
  logic hit_quarter;
  logic flag_raw;
  logic wr_align;
  logic wr_path;
  logic [7:0] rdata_d;

  // The async reset is released through two flops so every block leaves reset on one edge.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Alignment events from the pin, in the sensitivity chosen by software.
  align_pulse_detect u_pulse (
    .i_clk(i_clk),
    .i_rst_n(rst_n_q),
    .i_pin(i_align_pin),
    .i_edge_mode(pin_ctrl_q[BIT_PIN_EDGE_MODE]),
    .i_rising(pin_ctrl_q[BIT_PIN_RISING]),
    .o_event(pin_event)
  );

  // Per-unit delivery of an event; nothing passes without the master enable.
  assign master_on = align_ctrl_q[BIT_MASTER_EN];
  assign hit_clkdiv = pin_event & master_on & align_ctrl_q[BIT_CLKDIV_EN];
  assign hit_tune = pin_event & master_on & path_align_q[BIT_TUNE_EN];
  assign hit_fir = pin_event & master_on & path_align_q[BIT_FIR_EN];
  assign hit_quarter = pin_event & master_on & path_align_q[BIT_QUARTER_EN];

  assign wr_align = i_reg_wr && i_reg_addr == ADDR_ALIGN_CTRL;
  assign wr_path = i_reg_wr && i_reg_addr == ADDR_PATH_ALIGN;

  // Registered alignment pulses, one cycle after the pin event is seen.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_align_pulse <= '0;
    end else begin
      o_align_pulse.clk_divider <= hit_clkdiv;
      o_align_pulse.tunable_oscillator <= hit_tune;
      o_align_pulse.fir <= hit_fir;
      o_align_pulse.quarter_rate_oscillator <= hit_quarter;
    end
  end

  // Alignment pulse control: a host write in the same cycle as a self-clear wins, so a re-arm is kept.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      align_ctrl_q <= RST_ALIGN_CTRL;
    end else if (wr_align) begin
      align_ctrl_q <= {5'h00, i_reg_wdata[2:0]};
    end else if (hit_clkdiv && align_ctrl_q[BIT_CLKDIV_ONCE]) begin
      align_ctrl_q[BIT_CLKDIV_EN] <= 1'b0;
    end
  end

  // Datapath alignment control: each once bit drops its own enable after the first delivered pulse.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      path_align_q <= RST_PATH_ALIGN;
    end else if (wr_path) begin
      path_align_q <= i_reg_wdata & 8'hF3;
    end else begin
      if (hit_tune && path_align_q[BIT_TUNE_ONCE]) begin
        path_align_q[BIT_TUNE_EN] <= 1'b0;
      end
      if (hit_fir && path_align_q[BIT_FIR_ONCE]) begin
        path_align_q[BIT_FIR_EN] <= 1'b0;
      end
      if (hit_quarter && path_align_q[BIT_QUARTER_ONCE]) begin
        path_align_q[BIT_QUARTER_EN] <= 1'b0;
      end
    end
  end

  // Plain read-write configuration registers; open bits are not stored and read as zero.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_ctrl_q <= RST_PIN_CTRL;
      dc_ctrl_q <= RST_DC_CTRL;
      flag_ctrl_q <= RST_FLAG_CTRL;
      upper_q <= RST_LIMIT;
      lower_q <= RST_LIMIT;
      dwell_q <= RST_DWELL;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_PIN_CTRL: begin
          pin_ctrl_q <= i_reg_wdata & 8'h03;
        end
        ADDR_DC_CTRL: begin
          dc_ctrl_q <= i_reg_wdata & 8'h7E;
        end
        ADDR_FLAG_CTRL: begin
          flag_ctrl_q <= i_reg_wdata & 8'h0D;
        end
        ADDR_UPPER_LO: begin
          upper_q[7:0] <= i_reg_wdata;
        end
        ADDR_UPPER_HI: begin
          upper_q[12:8] <= i_reg_wdata[4:0];
        end
        ADDR_LOWER_LO: begin
          lower_q[7:0] <= i_reg_wdata;
        end
        ADDR_LOWER_HI: begin
          lower_q[12:8] <= i_reg_wdata[4:0];
        end
        ADDR_DWELL_LO: begin
          dwell_q[7:0] <= i_reg_wdata;
        end
        ADDR_DWELL_HI: begin
          dwell_q[15:8] <= i_reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Oscillator settings; the tuning word is assembled most significant byte first.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      osc_ctrl_q <= RST_OSC_CTRL;
      tuning_q <= RST_TUNING_WORD;
      phase_q <= RST_PHASE;
      osc_ctrl2_q <= RST_OSC_CTRL2;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_OSC_CTRL: begin
          osc_ctrl_q <= (i_reg_wdata & 8'h66) | OSC_CTRL_FIXED_ONES;
        end
        ADDR_TUNE_B3: begin
          tuning_q[31:24] <= i_reg_wdata;
        end
        ADDR_TUNE_B2: begin
          tuning_q[23:16] <= i_reg_wdata;
        end
        ADDR_TUNE_B1: begin
          tuning_q[15:8] <= i_reg_wdata;
        end
        ADDR_TUNE_B0: begin
          tuning_q[7:0] <= i_reg_wdata;
        end
        ADDR_PHASE_HI: begin
          phase_q[15:8] <= i_reg_wdata;
        end
        ADDR_PHASE_LO: begin
          phase_q[7:0] <= i_reg_wdata;
        end
        ADDR_OSC_CTRL2: begin
          osc_ctrl2_q <= i_reg_wdata & 8'h01;
        end
        default: begin
        end
      endcase
    end
  end

  // Settings out to the oscillators, each bit taken from its register flop.
  always_comb begin
    o_osc_cfg.tuning_word = tuning_q;
    o_osc_cfg.phase_offset = phase_q;
    o_osc_cfg.amplitude_dither = osc_ctrl_q[BIT_AMP_DITHER];
    o_osc_cfg.phase_dither = osc_ctrl_q[BIT_PHASE_DITHER];
    o_osc_cfg.spectral_reversal = osc_ctrl_q[BIT_SPECTRAL_REV];
    o_osc_cfg.quarter_rate_sync = osc_ctrl_q[BIT_QUARTER_SYNC];
    o_osc_cfg.low_latency_select = osc_ctrl2_q[BIT_LOW_LATENCY];
  end

  // Codes 14 and 15 are clamped so the estimator never runs slower than at 13.
  always_comb begin
    k_eff = dc_ctrl_q[BIT_DC_K_HI:BIT_DC_K_LO];
    if (k_eff > DC_K_MAX) begin
      k_eff = DC_K_MAX;
    end
  end

  // Leaky average of the input with a fractional tail; larger k means a longer time constant.
  always_comb begin
    err = ($signed({i_sample, {FRAC_W{1'b0}}}) - est_q) >>> k_eff;
    est_d = est_q + err;
  end

  // The estimate stands still while frozen and keeps being applied.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      est_q <= '0;
    end else if (!dc_ctrl_q[BIT_DC_FREEZE]) begin
      est_q <= est_d;
    end
  end

  assign dc_value = est_q[FRAC_W +: SAMPLE_W];

  // Corrected sample path; the subtraction wraps, so a large offset near full scale may overflow.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_sample <= '0;
    end else if (dc_ctrl_q[BIT_DC_EN]) begin
      o_sample <= i_sample - dc_value;
    end else begin
      o_sample <= i_sample;
    end
  end

  // Hysteresis comparator that produces the raw flag.
  threshold_flag_detect #(
    .MAG_W(MAG_W),
    .DWELL_W(DWELL_W)
  ) u_flag (
    .i_clk(i_clk),
    .i_rst_n(rst_n_q),
    .i_magnitude(i_magnitude),
    .i_upper(upper_q),
    .i_lower(lower_q),
    .i_dwell(dwell_q),
    .o_flag(flag_raw)
  );

  // Flag pin selection: force first, then comparator, else held low.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_threshold_flag <= 1'b0;
    end else if (flag_ctrl_q[BIT_FORCE_EN]) begin
      o_threshold_flag <= flag_ctrl_q[BIT_FORCE_VAL];
    end else if (flag_ctrl_q[BIT_FLAG_EN]) begin
      o_threshold_flag <= flag_raw;
    end else begin
      o_threshold_flag <= 1'b0;
    end
  end

  // Read multiplexer; unmapped indices read as zero.
  always_comb begin
    case (i_reg_addr)
      ADDR_ALIGN_CTRL: rdata_d = align_ctrl_q;
      ADDR_DC_CTRL: rdata_d = dc_ctrl_q;
      ADDR_DC_VALUE_LO: rdata_d = dc_value[7:0];
      ADDR_DC_VALUE_HI: rdata_d = dc_value[15:8];
      ADDR_FLAG_CTRL: rdata_d = flag_ctrl_q;
      ADDR_UPPER_LO: rdata_d = upper_q[7:0];
      ADDR_UPPER_HI: rdata_d = {3'h0, upper_q[12:8]};
      ADDR_LOWER_LO: rdata_d = lower_q[7:0];
      ADDR_LOWER_HI: rdata_d = {3'h0, lower_q[12:8]};
      ADDR_DWELL_LO: rdata_d = dwell_q[7:0];
      ADDR_DWELL_HI: rdata_d = dwell_q[15:8];
      ADDR_OSC_CTRL: rdata_d = osc_ctrl_q;
      ADDR_TUNE_B3: rdata_d = tuning_q[31:24];
      ADDR_TUNE_B2: rdata_d = tuning_q[23:16];
      ADDR_TUNE_B1: rdata_d = tuning_q[15:8];
      ADDR_TUNE_B0: rdata_d = tuning_q[7:0];
      ADDR_PHASE_HI: rdata_d = phase_q[15:8];
      ADDR_PHASE_LO: rdata_d = phase_q[7:0];
      ADDR_PATH_ALIGN: rdata_d = path_align_q;
      ADDR_PIN_CTRL: rdata_d = pin_ctrl_q;
      ADDR_OSC_CTRL2: rdata_d = osc_ctrl2_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data and its valid are registered; rdata holds until the next read.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_d;
      end
    end
  end

endmodule

/* ddc_feature_control_bank_checker.sv */
// Purpose: Port-level checks of the feature control bank.
// Assumes: Accesses follow the one-cycle strobe protocol of the register port.
// Notes: Shadow copies of a few registers are rebuilt from the write strobes.
module ddc_feature_control_bank_checker #(
  parameter int SAMPLE_W = 16,
  parameter int MAG_W = 13,
  parameter int DWELL_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_align_pin,
  input wire ddc_feature_pkg::align_pulse_s o_align_pulse,
  input wire logic signed [SAMPLE_W-1:0] i_sample,
  input wire logic signed [SAMPLE_W-1:0] o_sample,
  input wire logic [MAG_W-1:0] i_magnitude,
  input wire logic o_threshold_flag,
  input wire ddc_feature_pkg::osc_cfg_s o_osc_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  import ddc_feature_pkg::*;
  logic [7:0] ali_q;
  logic [7:0] dc_q;
  logic [7:0] flg_q;
  logic [12:0] upper_q;
  logic spent_q;

  // Shadow registers follow host writes only; the self-clear is tracked apart.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ali_q <= 8'h00;
      dc_q <= 8'h00;
      flg_q <= 8'h00;
      upper_q <= 13'h0000;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_ALIGN_CTRL: ali_q <= i_reg_wdata;
        ADDR_DC_CTRL: dc_q <= i_reg_wdata;
        ADDR_FLAG_CTRL: flg_q <= i_reg_wdata;
        ADDR_UPPER_LO: upper_q[7:0] <= i_reg_wdata;
        ADDR_UPPER_HI: upper_q[12:8] <= i_reg_wdata[4:0];
        default: ;
      endcase
    end
  end

  // Once a first-pulse-only delivery happened, only a host write may re-arm.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      spent_q <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == ADDR_ALIGN_CTRL) begin
      spent_q <= 1'b0;
    end else if (o_align_pulse.clk_divider && ali_q[BIT_CLKDIV_ONCE]) begin
      spent_q <= 1'b1;
    end
  end

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
  unmapped_zero_a: assert property (i_reg_rd && i_reg_addr == 8'h00 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  master_gate_a: assert property (!ali_q[BIT_MASTER_EN] |=> o_align_pulse == 4'h0)
    else $error("pulse with master enable clear");
  once_only_a: assert property (spent_q |-> !o_align_pulse.clk_divider)
    else $error("divider pulse after single shot");
  dc_bypass_a: assert property ($past(i_rst_n, 3) && !dc_q[BIT_DC_EN] |=> o_sample == $past(i_sample))
    else $error("sample altered without correction");
  force_value_a: assert property ($past(flg_q[BIT_FORCE_EN]) |-> o_threshold_flag == $past(flg_q[BIT_FORCE_VAL]))
    else $error("forced flag value wrong");
  flag_set_a: assert property ((flg_q[0] && !flg_q[3] && i_magnitude > upper_q) ##1 (flg_q[0] && !flg_q[3])
    |=> o_threshold_flag) else $error("flag not set above limit");
  flag_idle_a: assert property (!$past(flg_q[BIT_FORCE_EN]) && !$past(flg_q[BIT_FLAG_EN]) |-> !o_threshold_flag)
    else $error("flag high with nothing enabled");
  tune_byte_a: assert property (i_reg_wr && i_reg_addr == ADDR_TUNE_B3
    |=> o_osc_cfg.tuning_word[31:24] == $past(i_reg_wdata)) else $error("tuning byte not applied");

  cover property (o_align_pulse.clk_divider);
  cover property ($rose(o_threshold_flag));
  cover property (o_reg_rvalid);
endmodule

bind ddc_feature_control_bank ddc_feature_control_bank_checker #(.SAMPLE_W(SAMPLE_W), .MAG_W(MAG_W), .DWELL_W(DWELL_W))
  u_checker (.i_clk, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
  .i_align_pin, .o_align_pulse, .i_sample, .o_sample, .i_magnitude, .o_threshold_flag, .o_osc_cfg);

/* reg_host_model.sv */
// Purpose: Host controller driving the register strobe port.
// Assumes: One access at a time, launched just after a rising edge.
// Notes: Write data is inverted after each write so stale data never looks valid.
module reg_host_model (
  input wire logic i_clk,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // The port starts idle so nothing is taken during reset.
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // The write is taken at the edge that sees the strobe.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask

  // The answer is awaited for a bounded number of edges.
  task automatic read(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge i_clk);
      if (i_rvalid === 1'b1) begin
        ok = 1'b1;
        d = i_rdata;
      end
    end
  endtask
endmodule

/* ddc_feature_control_bank_test.sv */
// Purpose: Self-checking bench of the feature control bank.
// Assumes: The host model issues one register access at a time.
// Notes: Alignment pulses are counted per unit over two pin bursts.
module ddc_feature_control_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ddc_feature_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic wr;
  logic rd;
  logic rvalid;
  logic flag;
  logic pin = 1'b0;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic signed [15:0] smp = 16'sh0000;
  logic signed [15:0] osmp;
  logic [12:0] mag = 13'h0000;
  align_pulse_s pulse;
  osc_cfg_s osc;
  int n_mismatch = 0;
  int n_compared = 0;
  int cnt [4];
  logic [7:0] va;
  logic [7:0] vb;
  // Reset values, then write and read-back pairs.
  logic [7:0] ra [15] = '{8'h3A, 8'h40, 8'h45, 8'h47, 8'h48, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57,
    8'h58, 8'h59, 8'h5A};
  logic [7:0] rv [15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h51, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h01};
  logic [7:0] wt [10][3] = '{'{8'h48, 8'hFF, 8'h1F}, '{8'h51, 8'hFF, 8'h77}, '{8'h59, 8'hFF, 8'h03},
    '{8'h5A, 8'hFF, 8'h01}, '{8'h00, 8'hFF, 8'h00}, '{8'h41, 8'hFF, 8'h00}, '{8'h45, 8'hFF, 8'h0D},
    '{8'h45, 8'h00, 8'h00}, '{8'h58, 8'hFF, 8'hF3}, '{8'h3A, 8'hFF, 8'h07}};
  // Pin mode, 0x3A, 0x58, pulse counts per unit, then both read-backs.
  logic [7:0] at [4][9] = '{'{8'h00, 8'h03, 8'h51, 6, 6, 6, 6, 8'h03, 8'h51},
    '{8'h02, 8'h03, 8'h51, 2, 2, 2, 2, 8'h03, 8'h51}, '{8'h03, 8'h02, 8'h51, 0, 0, 0, 0, 8'h02, 8'h51},
    '{8'h03, 8'h07, 8'hF3, 1, 1, 1, 1, 8'h05, 8'hA2}};

  ddc_feature_control_bank u_ddc_feature_control_bank (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_align_pin(pin), .o_align_pulse(pulse), .i_sample(smp), .o_sample(osmp), .i_magnitude(mag),
    .o_threshold_flag(flag), .o_osc_cfg(osc));
  reg_host_model u_reg_host_model (.i_clk(i_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
    .i_rdata(rdata), .i_rvalid(rvalid));

  always #5 i_clk = ~i_clk;

  // Pulses are tallied per unit, indexed by bit of the pulse vector.
  always @(posedge i_clk) for (int b = 0; b < 4; b++) if (pulse[b] === 1'b1) cnt[b]++;

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    u_reg_host_model.write(a, d);
  endtask

  // A read that never answers ends the run at once.
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    bit ok;
    u_reg_host_model.read(a, d, ok);
    if (!ok) begin
      n_mismatch++;
      $display("Error read %0h expected answer seen none", a);
      print_verdict();
    end
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    get(a, d);
    check($sformatf("reg %0h", a), {24'h0, d}, {24'h0, exp});
  endtask

  // Two three-cycle pin bursts, then time for the pipeline to drain.
  task automatic burst();
    cnt = '{default: 0};
    repeat (2) begin
      @(posedge i_clk) pin <= 1'b1;
      repeat (3) @(posedge i_clk);
      pin <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    repeat (6) @(posedge i_clk);
  endtask

  // Settle on 100 with no averaging, step to 300 under code k, then freeze and read.
  task automatic dc_run(input logic [3:0] k, output logic [7:0] v);
    smp <= 16'sd100;
    wr_reg(ADDR_DC_CTRL, 8'h02);
    repeat (4) @(posedge i_clk);
    wr_reg(ADDR_DC_CTRL, {2'b00, k, 2'b10});
    smp <= 16'sd300;
    repeat (200) @(posedge i_clk);
    wr_reg(ADDR_DC_CTRL, {2'b01, k, 2'b10});
    get(ADDR_DC_VALUE_LO, v);
  endtask

  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    for (int i = 0; i < 15; i++) rd_check(ra[i], rv[i]);
    for (int i = 0; i < 10; i++) begin
      wr_reg(wt[i][0], wt[i][1]);
      rd_check(wt[i][0], wt[i][2]);
    end
    wr_reg(ADDR_PATH_ALIGN, 8'h00);
    for (int i = 0; i < 4; i++) wr_reg(ADDR_TUNE_B3 + 8'(i), 8'h12 + 8'(i) * 8'h22);
    wr_reg(ADDR_PHASE_HI, 8'hAB);
    wr_reg(ADDR_PHASE_LO, 8'hCD);
    @(posedge i_clk);
    check("tuning", osc.tuning_word, 32'h12345678);
    check("osc", {11'h0, osc.phase_offset, osc[4:0]}, {11'h0, 16'hABCD, 5'h1F});
    for (int r = 0; r < 4; r++) begin
      wr_reg(ADDR_PIN_CTRL, at[r][0]);
      wr_reg(ADDR_ALIGN_CTRL, at[r][1]);
      wr_reg(ADDR_PATH_ALIGN, at[r][2]);
      burst();
      for (int b = 0; b < 4; b++) check("pulses", cnt[3-b], {24'h0, at[r][3+b]});
      rd_check(ADDR_ALIGN_CTRL, at[r][7]);
      rd_check(ADDR_PATH_ALIGN, at[r][8]);
    end
    wr_reg(ADDR_ALIGN_CTRL, 8'h00);
    smp <= 16'sd100;
    wr_reg(ADDR_DC_CTRL, 8'h02);
    repeat (4) @(posedge i_clk);
    check("corrected", {16'h0, osmp}, 32'h0);
    wr_reg(ADDR_DC_CTRL, 8'h42);
    smp <= 16'sd300;
    repeat (4) @(posedge i_clk);
    check("frozen", {16'h0, osmp}, 32'd200);
    rd_check(ADDR_DC_VALUE_LO, 8'h64);
    dc_run(4'hF, va);
    dc_run(4'hD, vb);
    check("k clamp", {24'h0, va}, {24'h0, vb});
    wr_reg(ADDR_DC_CTRL, 8'h00);
    wr_reg(ADDR_UPPER_HI, 8'h12);
    wr_reg(ADDR_UPPER_LO, 8'h34);
    wr_reg(ADDR_LOWER_HI, 8'h10);
    wr_reg(ADDR_DWELL_LO, 8'h03);
    wr_reg(ADDR_FLAG_CTRL, 8'h01);
    mag <= 13'h1234;
    repeat (4) @(posedge i_clk);
    check("flag at limit", {31'h0, flag}, 32'h0);
    mag <= 13'h1235;
    repeat (3) @(posedge i_clk);
    check("flag above", {31'h0, flag}, 32'h1);
    mag <= 13'h0FFF;
    repeat (3) @(posedge i_clk);
    check("flag dwell", {31'h0, flag}, 32'h1);
    repeat (4) @(posedge i_clk);
    check("flag released", {31'h0, flag}, 32'h0);
    mag <= 13'h1FFF;
    wr_reg(ADDR_FLAG_CTRL, 8'h08);
    repeat (3) @(posedge i_clk);
    check("forced low", {31'h0, flag}, 32'h0);
    wr_reg(ADDR_FLAG_CTRL, 8'h0C);
    repeat (3) @(posedge i_clk);
    check("forced high", {31'h0, flag}, 32'h1);
    wr_reg(ADDR_FLAG_CTRL, 8'h00);
    repeat (3) @(posedge i_clk);
    check("flag idle", {31'h0, flag}, 32'h0);
    print_verdict();
  end
endmodule
